// ===== hw/rxst_pkg.sv
// package for the receive self-test and channel power block
package rxst_pkg;
	localparam int unsigned   RXST_CHANNELS    = 4;
	localparam int unsigned   RXST_BUS_W       = 8;
	localparam int unsigned   RXST_LFSR_W      = 9;
	localparam int unsigned   RXST_SEQ_LEN     = 511;
	// loop start code, all zero data character
	localparam logic [9:0]    RXST_START_CODE  = 10'h000;
	localparam logic [8:0]    RXST_LFSR_SEED   = 9'h1ff;
	localparam int unsigned   RXST_ERR_LIMIT   = 16;
	localparam logic [7:0]    RXST_ST_RESET    = 8'hff;
	localparam logic [7:0]    RXST_PWR_RESET   = 8'h00;
	// register offsets (byte addresses)
	localparam logic [7:0]    RXST_OFF_ENBUS   = 8'h00;
	localparam logic [7:0]    RXST_OFF_STROBE  = 8'h04;
	localparam logic [7:0]    RXST_OFF_LATCH   = 8'h08;
	localparam logic [7:0]    RXST_OFF_STATUS  = 8'h0c;
	// bit positions inside the strobe register
	localparam int unsigned   RXST_STB_ST      = 0;
	localparam int unsigned   RXST_STB_RX      = 1;
	localparam int unsigned   RXST_STB_TX      = 2;
	localparam logic [1:0]    RXST_RESP_OKAY   = 2'h0;
	localparam logic [1:0]    RXST_RESP_SLVERR = 2'h2;

	// three status bits: flag, bit0, bit1
	typedef struct packed {
		logic flag;
		logic bit0;
		logic bit1;
	} rxst_status_t;

	localparam rxst_status_t RXST_S_DATA  = '{1'b0, 1'b0, 1'b0};
	localparam rxst_status_t RXST_S_CMD   = '{1'b0, 1'b0, 1'b1};
	localparam rxst_status_t RXST_S_LGOOD = '{1'b0, 1'b1, 1'b0};
	localparam rxst_status_t RXST_S_LBAD  = '{1'b1, 1'b0, 1'b0};
	localparam rxst_status_t RXST_S_START = '{1'b1, 1'b0, 1'b1};
	localparam rxst_status_t RXST_S_ERR   = '{1'b1, 1'b1, 1'b0};
	localparam rxst_status_t RXST_S_WAIT  = '{1'b1, 1'b1, 1'b1};

	// one received character with its command mark
	typedef struct packed {
		logic       valid;
		logic       is_cmd;
		logic [9:0] code;
	} rxst_char_t;
endpackage

// ===== hw/rxst_top.sv
// receive self-test checkers and channel power latches, axi4-lite control
// Functional notes
// - strobe high: low bus bit enables that channel's self-test
// - self-test strobe falling captures bus, held until strobe rises
// - reset sets self-test latch all high, self-test off
// - enabled checker runs a 511-character pseudo-random shift register
// - on first enable the checker presets its shift register to the all-ones seed
// - once synchronised each character is compared and status reported
// - good data reports 000, good command 001, priority 7
// - loop end reports 010 if last good, 100 if bad
// - enabled but not comparing, or tracking reference, reports 101
// - a mismatching character reports 110
// - searching for loop start reports 111
// - errors exceeding matches by more than 16 abort and search again
// - rx strobe high: bus bit powers receive channel up or down
// - rx strobe falling captures bus, held until strobe rises
// - disabled receive channel holds link fault asserted
// - tx strobe high: bus bit enables or disables serial driver
// - tx strobe falling captures bus into output enable latch
// - reset clears transmit and receive enable latches
// - loss of lock forces checker back to start state
`timescale 1ns/1ns
module rxst_top
	import rxst_pkg::*;
#(
	// bus bit index per channel, 4 bits per channel
	parameter logic [15:0] RX_MAP = 16'h6420,
	parameter logic [15:0] TX_MAP = 16'h7531
) (
	// clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// axi4-lite write address and data
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// per-channel received characters and lock state
	input  wire rxst_char_t [3:0]        rx_char,
	input  wire logic [3:0]              rx_pll_lost_lock,
	input  wire logic [3:0]              rx_tracking_ref,
	input  wire logic [3:0]              rx_signal_ok,
	// per-channel outputs
	output logic [3:0]                   rx_selftest_active,
	output logic [3:0]                   tx_selftest_active,
	output logic [3:0]                   rx_power_en,
	output logic [3:0]                   tx_driver_en,
	output logic [3:0]                   link_fault_indicator,
	output logic [3:0]                   framing_match_flag,
	output logic [3:0][1:0]              rx_char_low_bits
);

	// software-driven enable bus and strobes
	logic [7:0] channel_enable_bus_q;
	logic [2:0] strobe_q;
	logic [7:0] st_latch_q;
	logic [7:0] rx_latch_q;
	logic [7:0] tx_latch_q;
	logic [7:0] st_eff;
	logic [7:0] rx_eff;
	logic [7:0] tx_eff;
	logic       selftest_latch_strobe;
	logic       rx_power_latch_strobe;
	logic       tx_power_latch_strobe;

	assign selftest_latch_strobe = strobe_q[RXST_STB_ST];
	assign rx_power_latch_strobe = strobe_q[RXST_STB_RX];
	assign tx_power_latch_strobe = strobe_q[RXST_STB_TX];

	// picks one bus bit by a 4-bit index taken from a map
	function automatic logic pick(input logic [7:0] bus,
	                              input logic [15:0] map,
	                              input int unsigned ch);
		logic [3:0] idx;
		idx = map[ch*4 +: 4];
		pick = bus[idx[2:0]];
	endfunction

	// transparent while strobe high, else the captured value
	assign st_eff = selftest_latch_strobe ? channel_enable_bus_q
	                                      : st_latch_q;
	assign rx_eff = rx_power_latch_strobe ? channel_enable_bus_q
	                                      : rx_latch_q;
	assign tx_eff = tx_power_latch_strobe ? channel_enable_bus_q
	                                      : tx_latch_q;

	// latches follow the bus while open, so the fall keeps the last value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_latch_q <= RXST_ST_RESET;
		end else if (selftest_latch_strobe) begin
			st_latch_q <= channel_enable_bus_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_latch_q <= RXST_PWR_RESET;
			tx_latch_q <= RXST_PWR_RESET;
		end else begin
			if (rx_power_latch_strobe)
				rx_latch_q <= channel_enable_bus_q;
			if (tx_power_latch_strobe)
				tx_latch_q <= channel_enable_bus_q;
		end
	end

	// per-channel enables, fixed mapping
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_map
			assign rx_power_en[g]        = pick(rx_eff, RX_MAP, g);
			assign tx_driver_en[g]       = pick(tx_eff, TX_MAP, g);
			assign rx_selftest_active[g] = !pick(st_eff, RX_MAP, g);
			assign tx_selftest_active[g] = !pick(st_eff, TX_MAP, g);
			// disabled channel holds fault asserted
			assign link_fault_indicator[g] = !rx_power_en[g] ||
			                                 !rx_signal_ok[g];
		end
	endgenerate

	// checker state per channel
	typedef enum logic [1:0] {
		RXST_IDLE,
		RXST_START,
		RXST_WAIT,
		RXST_RUN
	} rxst_state_t;

	rxst_state_t  st_q [4];
	logic [8:0]   lfsr_q [4];
	logic [8:0]   pos_q [4];
	logic signed [5:0] bal_q [4];
	rxst_status_t stat_q [4];

	// expected character: low nine bits from the shift register
	function automatic logic [9:0] expect_code(input logic [8:0] l);
		expect_code = {^l[8:5], l};
	endfunction

	generate
		for (g = 0; g < 4; g++) begin : g_chk
			rxst_char_t c;
			logic       match;
			logic       last;
			assign c     = rx_char[g];
			assign match = (c.code == expect_code(lfsr_q[g]));
			assign last  = (pos_q[g] == 9'(RXST_SEQ_LEN - 1));

			// checker state machine; loss of lock wins over all but reset, self-test off and power off
			always_ff @(posedge aclk) begin
				if (!aresetn || !rx_selftest_active[g] || !rx_power_en[g]) begin
					st_q[g]   <= RXST_IDLE;
					lfsr_q[g] <= RXST_LFSR_SEED;
					pos_q[g]  <= '0;
					bal_q[g]  <= '0;
				end else if (rx_pll_lost_lock[g]) begin
					st_q[g] <= RXST_START;
				end else begin
					unique case (st_q[g])
					RXST_IDLE: begin
						st_q[g]   <= RXST_START;
						lfsr_q[g] <= RXST_LFSR_SEED;
					end
					RXST_START: begin
						if (!rx_tracking_ref[g] && c.valid)
							st_q[g] <= RXST_WAIT;
					end
					RXST_WAIT: begin
						// arm on the loop start code
						if (c.valid && c.code == RXST_START_CODE) begin
							st_q[g]   <= RXST_RUN;
							lfsr_q[g] <= {lfsr_q[g][7:0],
							              lfsr_q[g][8] ^ lfsr_q[g][4]};
							pos_q[g]  <= 9'h001;
							bal_q[g]  <= '0;
						end
					end
					RXST_RUN: begin
						if (rx_tracking_ref[g]) begin
							st_q[g] <= RXST_START;
						end else if (c.valid) begin
							// 9-bit maximal sequence, period 511
							lfsr_q[g] <= {lfsr_q[g][7:0],
							              lfsr_q[g][8] ^ lfsr_q[g][4]};
							pos_q[g]  <= last ? '0 : pos_q[g] + 9'h001;
							if (!match &&
							    bal_q[g] == 6'(RXST_ERR_LIMIT)) begin
								st_q[g]   <= RXST_WAIT;
								lfsr_q[g] <= RXST_LFSR_SEED;
							end else if (match) begin
								bal_q[g] <= (bal_q[g] > 6'sd0) ?
								            bal_q[g] - 6'sd1 : bal_q[g];
							end else begin
								bal_q[g] <= bal_q[g] + 6'sd1;
							end
						end
					end
					endcase
				end
			end

			// status encoding, lowest priority number wins; 011 never used
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					stat_q[g] <= RXST_S_DATA;
				end else if (st_q[g] == RXST_START || rx_tracking_ref[g]) begin
					stat_q[g] <= RXST_S_START;
				end else if (st_q[g] == RXST_RUN && last && match) begin
					stat_q[g] <= RXST_S_LGOOD;
				end else if (st_q[g] == RXST_WAIT) begin
					stat_q[g] <= RXST_S_WAIT;
				end else if (st_q[g] == RXST_RUN && last) begin
					stat_q[g] <= RXST_S_LBAD;
				end else if (st_q[g] == RXST_RUN && !match) begin
					stat_q[g] <= RXST_S_ERR;
				end else if (st_q[g] == RXST_RUN) begin
					stat_q[g] <= c.is_cmd ? RXST_S_CMD
					                      : RXST_S_DATA;
				end else begin
					stat_q[g] <= RXST_S_DATA;
				end
			end

			assign framing_match_flag[g]  = stat_q[g].flag;
			assign rx_char_low_bits[g][0] = stat_q[g].bit0;
			assign rx_char_low_bits[g][1] = stat_q[g].bit1;
		end
	endgenerate

	// axi4-lite write path: address and data taken in either order
	logic        aw_have_q;
	logic        w_have_q;
	logic [7:0]  aw_q;
	logic [31:0] w_q;
	logic        wr_go;
	logic        wr_hit;

	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wr_hit = (aw_q == RXST_OFF_ENBUS) || (aw_q == RXST_OFF_STROBE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			aw_q         <= '0;
			w_q          <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RXST_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_q      <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RXST_RESP_OKAY : RXST_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control registers; only byte lane 0 carries bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			channel_enable_bus_q <= '0;
			strobe_q             <= '0;
		end else if (wr_go && s_axi_wstrb[0]) begin
			if (aw_q == RXST_OFF_ENBUS)
				channel_enable_bus_q <= w_q[7:0];
			if (aw_q == RXST_OFF_STROBE)
				strobe_q <= w_q[2:0];
		end
	end

	// read path, one read at a time
	logic [31:0] rd_mux;
	logic        rd_hit;
	always_comb begin
		rd_mux = '0;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
		RXST_OFF_ENBUS:  rd_mux = {24'h0, channel_enable_bus_q};
		RXST_OFF_STROBE: rd_mux = {29'h0, strobe_q};
		RXST_OFF_LATCH:  rd_mux = {8'h0, tx_latch_q, rx_latch_q, st_latch_q};
		RXST_OFF_STATUS: rd_mux = {8'h0, link_fault_indicator, 4'h0,
		                   rx_char_low_bits, framing_match_flag,
		                   rx_selftest_active};
		default:         rd_hit = 1'b0;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RXST_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_hit ? RXST_RESP_OKAY : RXST_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // rxst_top

// ===== tb/rxst_top_assertions.sv
// concurrent checks on the ports of the self-test and power block
`timescale 1ns/1ns
module rxst_top_assertions
	import rxst_pkg::*;
(
	// clock and reset
	input wire logic            aclk,
	input wire logic            aresetn,
	// bus handshakes
	input wire logic            s_axi_awvalid,
	input wire logic            s_axi_awready,
	input wire logic            s_axi_wvalid,
	input wire logic            s_axi_wready,
	input wire logic            s_axi_bvalid,
	input wire logic            s_axi_arvalid,
	input wire logic            s_axi_arready,
	input wire logic            s_axi_rvalid,
	// receive side
	input wire rxst_char_t [3:0] rx_char,
	input wire logic [3:0]      rx_pll_lost_lock,
	input wire logic [3:0]      rx_tracking_ref,
	// channel outputs
	input wire logic [3:0]      rx_selftest_active,
	input wire logic [3:0]      tx_selftest_active,
	input wire logic [3:0]      rx_power_en,
	input wire logic [3:0]      tx_driver_en,
	input wire logic [3:0]      link_fault_indicator,
	input wire logic [3:0]      framing_match_flag,
	input wire logic [3:0][1:0] rx_char_low_bits
);
	logic [1:0] wcnt_q;
	logic [3:0] rsv;
	logic [2:0] st0;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// cycles since the last write data beat; latches may move only then
	always_ff @(posedge aclk) begin
		if (!aresetn)
			wcnt_q <= 2'h3;
		else if (s_axi_wvalid && s_axi_wready)
			wcnt_q <= 2'h0;
		else if (wcnt_q != 2'h3)
			wcnt_q <= wcnt_q + 2'h1;
	end
	// reserved code per channel, flag low with both data bits high
	always_comb begin
		for (int i = 0; i < 4; i++)
			rsv[i] = !framing_match_flag[i] && (&rx_char_low_bits[i]);
	end
	assign st0 = {framing_match_flag[0], rx_char_low_bits[0]};
	property p_rsv; rsv == 4'h0; endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved status code seen");
	property p_rst; $rose(aresetn) |-> ({rx_power_en, tx_driver_en,
		rx_selftest_active, tx_selftest_active} == 16'h0); endproperty
	a_rst: assert property (p_rst)
		else $error("channels not off after reset");
	property p_lfi; (~rx_power_en & ~link_fault_indicator) == 4'h0;
	endproperty
	a_lfi: assert property (p_lfi)
		else $error("powered down channel without link fault");
	property p_hold; $past(aresetn) && $changed({rx_power_en, tx_driver_en,
		rx_selftest_active, tx_selftest_active}) |-> wcnt_q != 2'h3;
	endproperty
	a_hold: assert property (p_hold)
		else $error("channel enable moved without a write");
	property p_lock; (rx_selftest_active[0] && (rx_pll_lost_lock[0] ||
		rx_tracking_ref[0])) [*3] |-> st0 == 3'b110; endproperty
	a_lock: assert property (p_lock)
		else $error("start status missing while unlocked");
	property p_err; $rose(st0 == 3'b101) |-> $past(rx_char[0].valid) ||
		$past(rx_char[0].valid, 2) || $past(rx_char[0].valid, 3);
	endproperty
	a_err: assert property (p_err)
		else $error("error status without a received character");
	property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_ar: assert property (p_ar)
		else $error("read answer late");
	property p_aw; s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##2 s_axi_bvalid; endproperty
	a_aw: assert property (p_aw)
		else $error("write answer late");
endmodule // rxst_top_assertions

bind rxst_top rxst_top_assertions rxst_top_assertions_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .rx_char(rx_char),
	.rx_pll_lost_lock(rx_pll_lost_lock), .rx_tracking_ref(rx_tracking_ref),
	.rx_selftest_active(rx_selftest_active),
	.tx_selftest_active(tx_selftest_active), .rx_power_en(rx_power_en),
	.tx_driver_en(tx_driver_en), .link_fault_indicator(link_fault_indicator),
	.framing_match_flag(framing_match_flag),
	.rx_char_low_bits(rx_char_low_bits));

// ===== tb/rxst_far_tx.sv
// far end character source feeding one receive channel
`timescale 1ns/1ns
module rxst_far_tx
	import rxst_pkg::*;
(
	// clock
	input  wire logic       aclk,
	// 0 idle, 1 corrupted stream, 2 loop start code, 3 test sequence
	input  wire logic [1:0] mode,
	// character towards the receiver
	output rxst_char_t      ch
);
	logic [8:0] p;
	initial ch = '0;
	initial p = RXST_LFSR_SEED;
	// characters arrive already framed, no low-latency framer here
	// idle keeps the code lines toggling so no stale value looks real
	always @(posedge aclk) begin
		case (mode)
		2'h1: ch <= '{1'b1, 1'b0, 10'h2aa};
		2'h2: begin
			ch <= '{1'b1, 1'b0, RXST_START_CODE};
			p  <= {RXST_LFSR_SEED[7:0],
			       RXST_LFSR_SEED[8] ^ RXST_LFSR_SEED[4]};
		end
		// matching generator; top bit marks a command character
		2'h3: begin
			ch <= '{1'b1, p[8], {^p[8:5], p}};
			p  <= {p[7:0], p[8] ^ p[4]};
		end
		default: ch <= '{1'b0, 1'b0, ~ch.code};
		endcase
	end
endmodule // rxst_far_tx

// ===== tb/rxst_top_tb.sv
// self-checking bench for the self-test and channel power block
`timescale 1ns/1ns
module rxst_top_tb
	import rxst_pkg::*;
;
	logic aclk, aresetn, awvalid, wvalid, bvalid, arvalid, rvalid;
	logic awready, wready, arready, bready, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, mode;
	logic [3:0] lost, track, rx_st, tx_st, rx_pw, tx_pw, lfi, flag;
	logic [3:0][1:0] low;
	logic [2:0] st0;
	rxst_char_t far_ch;
	rxst_char_t [3:0] rx_char;
	int bad_count, n_checks;
	assign rx_char = {36'h0, far_ch};
	assign st0 = {flag[0], low[0]};
	always #5 aclk = ~aclk;
	rxst_top rxst_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rx_char(rx_char), .rx_pll_lost_lock(lost),
		.rx_tracking_ref(track), .rx_signal_ok(4'hf),
		.rx_selftest_active(rx_st), .tx_selftest_active(tx_st),
		.rx_power_en(rx_pw), .tx_driver_en(tx_pw),
		.link_fault_indicator(lfi), .framing_match_flag(flag),
		.rx_char_low_bits(low));
	rxst_far_tx rxst_far_tx_inst (.aclk(aclk), .mode(mode), .ch(far_ch));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	// address and data offered together, each released once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int i;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		chk(i < 40 && bresp === er, "write response");
		if (i >= 40)
			finish_test();
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int i;
		araddr <= a;
		arvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		chk(i < 40 && rresp === er && rdata === ed, "read data");
		if (i >= 40)
			finish_test();
	endtask
	task automatic wait_st(input logic [2:0] e, input int n);
		int i;
		for (i = 0; i < n && st0 !== e; i++)
			@(posedge aclk);
		chk(st0 === e, "self-test status");
		if (st0 !== e)
			finish_test();
	endtask
	// matching sequence: good compares, then loop end reported good
	task automatic t_loop();
		int i;
		int nd;
		int nc;
		nd = 0;
		nc = 0;
		mode <= 2'h2;
		@(posedge aclk);
		mode <= 2'h3;
		repeat (3) @(posedge aclk);
		for (i = 0; i < 600 && st0 !== 3'b001; i++) begin
			if (st0 === 3'b000)
				nd++;
			if (st0 === 3'b010)
				nc++;
			@(posedge aclk);
		end
		chk(i < 600, "loop good status");
		chk(nd > 0 && nc > 0 && nd + nc > 500, "good compares");
		mode <= 2'h0;
		if (i >= 600)
			finish_test();
	endtask
	task automatic t_reset();
		chk(rx_pw === 4'h0 && tx_pw === 4'h0, "power after reset");
		chk(rx_st === 4'h0 && tx_st === 4'h0, "test after reset");
		chk(lfi === 4'hf, "link fault after reset");
		axi_rd(RXST_OFF_LATCH, 32'h0000_00ff, RXST_RESP_OKAY);
	endtask
	// host pulses each strobe around a bus value
	task automatic t_rx();
		axi_wr(RXST_OFF_ENBUS, 32'h05, RXST_RESP_OKAY);
		axi_wr(RXST_OFF_STROBE, 32'h1 << RXST_STB_RX, RXST_RESP_OKAY);
		chk(rx_pw === 4'h3 && tx_pw === 4'h0, "rx power open");
		axi_wr(RXST_OFF_STROBE, 32'h0, RXST_RESP_OKAY);
		axi_wr(RXST_OFF_ENBUS, 32'h00, RXST_RESP_OKAY);
		chk(rx_pw === 4'h3, "rx power held");
		chk(lfi[3:2] === 2'h3, "link fault when off");
	endtask
	task automatic t_tx();
		axi_wr(RXST_OFF_ENBUS, 32'h0a, RXST_RESP_OKAY);
		axi_wr(RXST_OFF_STROBE, 32'h1 << RXST_STB_TX, RXST_RESP_OKAY);
		chk(tx_pw === 4'h3, "tx driver open");
		axi_wr(RXST_OFF_STROBE, 32'h0, RXST_RESP_OKAY);
		axi_wr(RXST_OFF_ENBUS, 32'hff, RXST_RESP_OKAY);
		chk(tx_pw === 4'h3 && rx_pw === 4'h3, "tx driver held");
	endtask
	task automatic t_st();
		axi_wr(RXST_OFF_ENBUS, 32'hfe, RXST_RESP_OKAY);
		axi_wr(RXST_OFF_STROBE, 32'h1 << RXST_STB_ST, RXST_RESP_OKAY);
		chk(rx_st === 4'h1 && tx_st === 4'h0, "test latch open");
		axi_wr(RXST_OFF_STROBE, 32'h0, RXST_RESP_OKAY);
		axi_wr(RXST_OFF_ENBUS, 32'hff, RXST_RESP_OKAY);
		chk(rx_st === 4'h1, "test latch held");
		axi_rd(RXST_OFF_LATCH, 32'h000a_05fe, RXST_RESP_OKAY);
	endtask
	task automatic t_bad_addr();
		axi_wr(8'h10, 32'h1, RXST_RESP_SLVERR);
		axi_rd(8'h10, 32'h0, RXST_RESP_SLVERR);
	endtask
	// channel 0 checker: unlocked, searching, error run and abort
	task automatic t_status();
		track <= 4'h1;
		repeat (4) @(posedge aclk);
		wait_st(3'b110, 20);
		track <= 4'h0;
		mode <= 2'h1;
		wait_st(3'b111, 20);
		lost <= 4'h1;
		repeat (4) @(posedge aclk);
		wait_st(3'b110, 20);
		lost <= 4'h0;
		wait_st(3'b111, 20);
		mode <= 2'h2;
		@(posedge aclk);
		mode <= 2'h1;
		wait_st(3'b101, 20);
		wait_st(3'b111, 80);
		mode <= 2'h0;
	endtask
	initial begin
		{aclk, aresetn, awvalid, wvalid, arvalid} = '0;
		{awaddr, araddr, wdata, mode, lost, track} = '0;
		bready = 1'b1;
		rready = 1'b1;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_rx();
		t_tx();
		t_st();
		t_bad_addr();
		t_status();
		t_loop();
		finish_test();
	end
endmodule // rxst_top_tb
